// >>> src/sbs_bank.sv
// Purpose: One bank's state and timer
// Assumes: Legality decided by the parent
// Notes: Command pulses are one cycle wide
`timescale 1ns/100ps
`default_nettype none
`include "sbs_map.svh"
module sbs_bank
   import sbs_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         do_act,
   input  wire logic         do_rd,
   input  wire logic         do_wr,
   input  wire logic         ap,
   input  wire logic         do_pre,
   input  wire logic         burst_end,
   input  wire logic         intr_other,
   input  wire logic         intr_is_wr,
   input  wire logic         all_idle_set,
   output sbs_bank_st_t      state
);
   sbs_bank_st_t st_q, st_d;
   logic [3:0]   tmr_q, tmr_d;
   logic         wr_rec_q, wr_rec_d;
   wire          tmr_done = (tmr_q == 4'h0);

   assign state = st_q;

   always_comb
   begin
      st_d     = st_q;
      tmr_d    = (tmr_q == 4'h0) ? 4'h0 : tmr_q - 4'h1;
      wr_rec_d = wr_rec_q;
      case (st_q)
         SBS_ST_IDLE:
         begin
            if (do_act)
            begin
               st_d  = SBS_ST_ACTV;
               tmr_d = `SBS_ACT_TO_COL_DELAY_CYC - 4'h1;
            end
         end
         SBS_ST_ACTV:
            if (tmr_done)
               st_d = SBS_ST_ROWACT;
         SBS_ST_ROWACT, SBS_ST_READ, SBS_ST_WRITE:
         begin
            if (do_pre)
            begin
               st_d  = SBS_ST_PRE;
               tmr_d = `SBS_PRECHARGE_PERIOD_CYC - 4'h1;
            end
            else if (do_rd || do_wr)
            begin
               st_d     = ap ? (do_rd ? SBS_ST_RDAP : SBS_ST_WRAP)
                             : (do_rd ? SBS_ST_READ : SBS_ST_WRITE);
               tmr_d    = 4'hf;
               wr_rec_d = 1'b0;
            end
            else if (st_q != SBS_ST_ROWACT && (burst_end || intr_other))
               st_d = SBS_ST_ROWACT;
         end
         SBS_ST_RDAP, SBS_ST_WRAP:
         begin
            if (tmr_q == 4'hf)
               tmr_d = 4'hf;                                 // Hold marker while burst runs
            if (tmr_q == 4'hf && (burst_end || intr_other))
            begin
               if (st_q == SBS_ST_WRAP)
               begin
                  tmr_d    = `SBS_WRITE_RECOVERY_CYC + `SBS_PRECHARGE_PERIOD_CYC - 4'h1;
                  wr_rec_d = 1'b1;
               end
               else
                  tmr_d = `SBS_PRECHARGE_PERIOD_CYC - 4'h1;
            end
            else if (tmr_q != 4'hf && tmr_done)
               st_d = SBS_ST_IDLE;
         end
         SBS_ST_PRE:
            if (tmr_done)
               st_d = SBS_ST_IDLE;
         default:
            st_d = SBS_ST_IDLE;
      endcase
      if (all_idle_set)
         st_d = SBS_ST_IDLE;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_q     <= SBS_ST_IDLE;
         tmr_q    <= 4'h0;
         wr_rec_q <= 1'b0;
      end
      else
      begin
         st_q     <= st_d;
         tmr_q    <= tmr_d;
         wr_rec_q <= wr_rec_d;
      end
   end
   wire unused_ok = intr_is_wr & wr_rec_q;
endmodule
`default_nettype wire

// >>> src/sbs_map.svh
// Purpose: Timing counts and field positions for the bank state tracker
// Assumes: Counts are whole cycles of clk_sys at 20 MHz
// Notes: Defaults chosen small; adjust per part grade
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH
`define SBS_PRECHARGE_PERIOD_CYC      4'h2
`define SBS_ACT_TO_COL_DELAY_CYC      4'h2
`define SBS_REFRESH_CYCLE_CYC         4'h4
`define SBS_MODE_LOAD_DELAY_CYC       4'h2
`define SBS_WRITE_RECOVERY_CYC        4'h2
`define SBS_SELF_REFRESH_EXIT_CYC     4'h3
`define SBS_READ_LATENCY_DEF          2'h2
`define SBS_BURST_LEN_DEF             4'h4
`define SBS_AP_BIT                    10
`define SBS_NUM_BANKS                 4
`endif

// >>> src/sbs_pkg.sv
// Purpose: Types for the bank state tracker
// Assumes: Four banks, 12 address bits
// Notes: Command codes follow the pin encoding cs,ras,cas,we
package sbs_pkg;
   typedef enum logic [3:0]
   {
      SBS_CMD_NOP   = 4'h7,
      SBS_CMD_ACT   = 4'h3,
      SBS_CMD_READ  = 4'h5,
      SBS_CMD_WRITE = 4'h4,
      SBS_CMD_BST   = 4'h6,
      SBS_CMD_PRE   = 4'h2,
      SBS_CMD_REF   = 4'h1,
      SBS_CMD_MRS   = 4'h0
   } sbs_cmd_t;

   typedef enum logic [7:0]
   {
      SBS_ST_IDLE   = 8'h01,
      SBS_ST_ACTV   = 8'h02,
      SBS_ST_ROWACT = 8'h04,
      SBS_ST_READ   = 8'h08,
      SBS_ST_WRITE  = 8'h10,
      SBS_ST_RDAP   = 8'h20,
      SBS_ST_WRAP   = 8'h40,
      SBS_ST_PRE    = 8'h80
   } sbs_bank_st_t;

   typedef enum logic [3:0]
   {
      SBS_DV_NORMAL = 4'h1,
      SBS_DV_REFR   = 4'h2,
      SBS_DV_MODE   = 4'h4,
      SBS_DV_PREALL = 4'h8
   } sbs_dev_st_t;

   typedef struct packed
   {
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [1:0]  bank_select;
      logic [11:0] addr;
      logic        lower_byte_lane_mask;
      logic        upper_byte_lane_mask;
   } sbs_cmd_bus_t;
endpackage

// >>> src/sbs_tracker.sv
// Purpose: Four-bank state tracking and command legality checker
// Assumes: Commands sampled on clk_sys; cke is a pin input
// Notes: Illegal commands are flagged and not acted on
`timescale 1ns/100ps
`default_nettype none
`include "sbs_map.svh"
module sbs_tracker
   import sbs_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         cke,
   input  wire logic         self_refresh_exit,
   input  wire sbs_cmd_bus_t cmd_bus,
   input  wire logic [1:0]   read_latency,
   input  wire logic [3:0]   burst_length,
   output logic [31:0]       bank_state_flat,
   output logic              device_busy,
   output logic              all_banks_idle,
   output logic              illegal_cmd,
   output logic              cmd_taken
);
   logic [2:0]    cke_sync_q;
   logic          cke_cur_q, cke_prev_q;
   logic [3:0]    xsr_q;
   sbs_dev_st_t   dev_q, dev_d;
   logic [3:0]    dtmr_q, dtmr_d;
   logic [1:0]    last_bank_q;
   logic          last_valid_q;
   logic          last_is_wr_q;
   logic [3:0]    bcnt_q;
   logic [1:0]    rl_q;
   logic          rd_intr_pend_q;
   logic [1:0]    rd_intr_bank_q;
   logic          illegal_q, taken_q;
   sbs_bank_st_t  bst [4];

   function automatic logic is_busy(input sbs_bank_st_t s);
      is_busy = (s == SBS_ST_ACTV) || (s == SBS_ST_PRE);
   endfunction

   function automatic logic can_col(input sbs_bank_st_t s);
      can_col = (s == SBS_ST_ROWACT) || (s == SBS_ST_READ) || (s == SBS_ST_WRITE);
   endfunction

   // Pin synchroniser: stage 0 read only by stage 1
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         cke_sync_q <= 3'h0;
      else
         cke_sync_q <= {cke_sync_q[1:0], cke};
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cke_cur_q  <= 1'b0;
         cke_prev_q <= 1'b0;
      end
      else
      begin
         if (cke_sync_q[1] == cke_sync_q[2])
            cke_cur_q <= cke_sync_q[2];
         cke_prev_q <= cke_cur_q;
      end
   end

   // Self refresh exit hold-off
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         xsr_q <= 4'h0;
      else if (self_refresh_exit)
         xsr_q <= `SBS_SELF_REFRESH_EXIT_CYC;
      else if (xsr_q != 4'h0)
         xsr_q <= xsr_q - 4'h1;
   end

   wire       active   = cke_cur_q && cke_prev_q && (xsr_q == 4'h0);
   wire [3:0] code     = {cmd_bus.cs_n, cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n};
   wire       inhibit  = cmd_bus.cs_n;
   wire [1:0] ba       = cmd_bus.bank_select;
   wire       a10      = cmd_bus.addr[`SBS_AP_BIT];
   wire       c_act    = active && !inhibit && code == SBS_CMD_ACT;
   wire       c_rd     = active && !inhibit && code == SBS_CMD_READ;
   wire       c_wr     = active && !inhibit && code == SBS_CMD_WRITE;
   wire       c_bst    = active && !inhibit && code == SBS_CMD_BST;
   wire       c_pre    = active && !inhibit && code == SBS_CMD_PRE;
   wire       c_ref    = active && !inhibit && code == SBS_CMD_REF;
   wire       c_mrs    = active && !inhibit && code == SBS_CMD_MRS;
   wire       c_any    = c_act | c_rd | c_wr | c_bst | c_pre | c_ref | c_mrs;
   wire       dev_free = (dev_q == SBS_DV_NORMAL);

   logic [3:0] idle_v, busy_v, prech_ok_v;
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         idle_v[i]     = (bst[i] == SBS_ST_IDLE);
         busy_v[i]     = is_busy(bst[i]) || bst[i] == SBS_ST_RDAP || bst[i] == SBS_ST_WRAP;
         prech_ok_v[i] = !busy_v[i] || bst[i] == SBS_ST_PRE;
      end
   end

   wire all_idle  = &idle_v;
   wire tgt_busy  = busy_v[ba];
   wire tgt_idle  = idle_v[ba];
   wire pre_all   = c_pre && a10;
   wire ok_act    = c_act && tgt_idle;
   wire ok_col    = (c_rd || c_wr) && can_col(bst[ba]);
   wire ok_pre1   = c_pre && !a10 && !tgt_busy;
   wire ok_preall = pre_all && (&prech_ok_v);
   wire ok_ref    = (c_ref || c_mrs) && all_idle;
   wire ok_bst    = c_bst;
   wire legal     = dev_free && (ok_preall || ok_ref || ok_bst
                    || (!tgt_busy && (ok_act || ok_col || ok_pre1)));
   wire bad       = c_any && !legal;
   wire go        = c_any && !bad;

   // Device-wide busy states
   always_comb
   begin
      dev_d  = dev_q;
      dtmr_d = (dtmr_q == 4'h0) ? 4'h0 : dtmr_q - 4'h1;
      case (dev_q)
         SBS_DV_NORMAL:
         begin
            if (go && c_ref)
            begin
               dev_d  = SBS_DV_REFR;
               dtmr_d = `SBS_REFRESH_CYCLE_CYC - 4'h1;
            end
            else if (go && c_mrs)
            begin
               dev_d  = SBS_DV_MODE;
               dtmr_d = `SBS_MODE_LOAD_DELAY_CYC - 4'h1;
            end
            else if (go && pre_all)
            begin
               dev_d  = SBS_DV_PREALL;
               dtmr_d = `SBS_PRECHARGE_PERIOD_CYC - 4'h1;
            end
         end
         SBS_DV_REFR, SBS_DV_MODE, SBS_DV_PREALL:
            if (dtmr_q == 4'h0)
               dev_d = SBS_DV_NORMAL;
         default:
            dev_d = SBS_DV_NORMAL;
      endcase
   end

   wire dev_done = (dev_q != SBS_DV_NORMAL) && (dtmr_q == 4'h0);

   // Burst tracking for terminate and natural end
   wire new_burst = go && (c_rd || c_wr);
   wire bcnt_end  = last_valid_q && (bcnt_q == 4'h1);
   wire rd_rd     = new_burst && c_rd && last_valid_q && !last_is_wr_q && last_bank_q != ba;
   wire rd_cut    = rd_intr_pend_q && (rl_q == 2'h0);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         last_valid_q   <= 1'b0;
         last_bank_q    <= 2'h0;
         last_is_wr_q   <= 1'b0;
         bcnt_q         <= 4'h0;
         rd_intr_pend_q <= 1'b0;
         rd_intr_bank_q <= 2'h0;
         rl_q           <= 2'h0;
      end
      else
      begin
         if (new_burst)
         begin
            last_valid_q <= 1'b1;
            last_bank_q  <= ba;
            last_is_wr_q <= c_wr;
            bcnt_q       <= burst_length;
         end
         else if ((go && c_bst) || bcnt_end)
            last_valid_q <= 1'b0;
         else if (bcnt_q != 4'h0)
            bcnt_q <= bcnt_q - 4'h1;
         if (rd_rd)
         begin
            rd_intr_pend_q <= 1'b1;
            rd_intr_bank_q <= last_bank_q;
            rl_q           <= read_latency - 2'h1;
         end
         else if (rd_intr_pend_q)
         begin
            if (rl_q == 2'h0)
               rd_intr_pend_q <= 1'b0;
            else
               rl_q <= rl_q - 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         dev_q     <= SBS_DV_NORMAL;
         dtmr_q    <= 4'h0;
         illegal_q <= 1'b0;
         taken_q   <= 1'b0;
      end
      else
      begin
         dev_q     <= dev_d;
         dtmr_q    <= dtmr_d;
         illegal_q <= bad;
         taken_q   <= go;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : gb
         wire mine   = (ba == 2'(g));
         wire other  = new_burst && !mine && last_valid_q && last_bank_q == 2'(g);
         // Read-to-read on plain read waits the read latency; others cut at once
         wire intr   = (other && !(c_rd && bst[g] == SBS_ST_READ))
                       || (rd_cut && rd_intr_bank_q == 2'(g));
         wire endb   = last_valid_q && last_bank_q == 2'(g)
                       && ((go && c_bst) || bcnt_end);
         sbs_bank u_bank
         (
            .clk_sys      (clk_sys),
            .rst          (rst),
            .do_act       (go && c_act && mine),
            .do_rd        (go && c_rd && mine),
            .do_wr        (go && c_wr && mine),
            .ap           (a10),
            .do_pre       (go && c_pre && !a10 && mine),
            .burst_end    (endb),
            .intr_other   (intr),
            .intr_is_wr   (c_wr),
            .all_idle_set (dev_done),
            .state        (bst[g])
         );
         assign bank_state_flat[8*g +: 8] = bst[g];
      end
   endgenerate

   assign device_busy    = !dev_free;
   assign all_banks_idle = all_idle && dev_free;
   assign illegal_cmd    = illegal_q;
   assign cmd_taken      = taken_q;
endmodule
`default_nettype wire

// >>> tb/sbs_ctl_model.sv
// Purpose: Controller model driving the command pins
// Assumes: Bench requests by non-blocking assignment
// Notes: Deselected lines toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module sbs_ctl_model
   import sbs_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        req,
   input  wire sbs_cmd_t    req_cmd,
   input  wire logic [1:0]  req_bank,
   input  wire logic        req_a10,
   output var sbs_cmd_bus_t cmd_bus
);
   logic [11:0] idle_q;
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         idle_q <= 12'h5a5;
      else
         idle_q <= ~idle_q;
   // Inhibit when no request
   always_comb
   begin
      {cmd_bus.cs_n, cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n} = req ? req_cmd : 4'hf;
      cmd_bus.bank_select = req ? req_bank : idle_q[1:0];
      cmd_bus.addr = idle_q;
      cmd_bus.addr[10] = req ? req_a10 : idle_q[10];
      cmd_bus.lower_byte_lane_mask = !(req && req_cmd == SBS_CMD_WRITE);
      cmd_bus.upper_byte_lane_mask = !(req && req_cmd == SBS_CMD_WRITE);
   end
endmodule
`default_nettype wire

// >>> tb/sbs_tracker_sva.sv
// Purpose: Port checker for the tracker
// Assumes: Default timing counts
// Notes: Bound after the module
`timescale 1ns/100ps
`default_nettype none
module sbs_tracker_chk
   import sbs_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         cke,
   input  wire logic         self_refresh_exit,
   input  wire sbs_cmd_bus_t cmd_bus,
   input  wire logic [1:0]   read_latency,
   input  wire logic [3:0]   burst_length,
   input  wire logic [31:0]  bank_state_flat,
   input  wire logic         device_busy,
   input  wire logic         all_banks_idle,
   input  wire logic         illegal_cmd,
   input  wire logic         cmd_taken
);
   wire logic [3:0] code = {cmd_bus.cs_n, cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n};
   wire logic [7:0] st0  = bank_state_flat[7:0];
   wire logic       b0   = cmd_bus.bank_select == 2'h0;
   wire logic       a10  = cmd_bus.addr[10];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   excl_pulse_a: assert property (!(cmd_taken && illegal_cmd)) else $error("taken and illegal together");
   onehot_state_a: assert property ($onehot(st0) && $onehot(bank_state_flat[15:8])
      && $onehot(bank_state_flat[23:16]) && $onehot(bank_state_flat[31:24])) else $error("bank state not one-hot");
   idle_summary_a: assert property (all_banks_idle == (bank_state_flat == 32'h01010101 && !device_busy))
      else $error("all idle flag wrong");
   act_rowact_a: assert property (st0 == SBS_ST_ACTV |-> ##[1:3] st0 == SBS_ST_ROWACT) else $error("activate stuck");
   pre_idle_a: assert property (st0 == SBS_ST_PRE |-> ##[1:3] st0 == SBS_ST_IDLE) else $error("precharge stuck");
   busy_ends_a: assert property (device_busy |-> ##[1:5] !device_busy) else $error("device busy too long");
   ref_idle_a: assert property (code == SBS_CMD_REF && !all_banks_idle |=> illegal_cmd)
      else $error("refresh not refused");
   act_busy_a: assert property (code == SBS_CMD_ACT && b0 && st0 != SBS_ST_IDLE |=> illegal_cmd)
      else $error("activate not refused");
   pre_nop_a: assert property (code == SBS_CMD_PRE && b0 && !a10 && st0 == SBS_ST_IDLE && !device_busy
      |=> cmd_taken && st0 == SBS_ST_IDLE) else $error("idle precharge acted");
   rd_ap_a: assert property (code == SBS_CMD_READ && b0 && a10 && st0 == SBS_ST_ROWACT && !device_busy
      |-> ##[1:2] st0 == SBS_ST_RDAP) else $error("read no auto precharge");
   cover property (st0 == SBS_ST_RDAP);
   cover property ($rose(device_busy));
   cover property (illegal_cmd);
endmodule
bind sbs_tracker sbs_tracker_chk i_chk (.clk_sys(clk_sys), .rst(rst), .cke(cke),
   .self_refresh_exit(self_refresh_exit), .cmd_bus(cmd_bus), .read_latency(read_latency),
   .burst_length(burst_length), .bank_state_flat(bank_state_flat), .device_busy(device_busy),
   .all_banks_idle(all_banks_idle), .illegal_cmd(illegal_cmd), .cmd_taken(cmd_taken));
`default_nettype wire

// >>> tb/sbs_tracker_tb.sv
// Purpose: Command sequence tests for the tracker
// Assumes: Default timing counts, latency 2, burst 4
// Notes: Waits are bounded
`timescale 1ns/100ps
`default_nettype none
module sbs_tracker_tb
   import sbs_pkg::*;
;
   logic         clk_sys, rst, cke, srx, req, a10;
   sbs_cmd_t     cmd;
   logic [1:0]   bank;
   sbs_cmd_bus_t cmd_bus;
   logic [31:0]  bank_state_flat;
   logic         device_busy, all_banks_idle, illegal_cmd, cmd_taken;
   int           n_errors = 0;
   int           n_tests = 0;
   int           k;
   sbs_ctl_model i_ctl (.clk_sys(clk_sys), .rst(rst), .req(req), .req_cmd(cmd), .req_bank(bank),
      .req_a10(a10), .cmd_bus(cmd_bus));
   sbs_tracker i_dut (.clk_sys(clk_sys), .rst(rst), .cke(cke), .self_refresh_exit(srx), .cmd_bus(cmd_bus),
      .read_latency(2'h2), .burst_length(4'h4), .bank_state_flat(bank_state_flat), .device_busy(device_busy),
      .all_banks_idle(all_banks_idle), .illegal_cmd(illegal_cmd), .cmd_taken(cmd_taken));
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   // Held until the sampling edge; bb keeps the request for a following command
   task automatic send(input sbs_cmd_t c, input logic [1:0] b, input logic a, input logic bb);
      req <= 1'b1;
      cmd <= c;
      bank <= b;
      a10 <= a;
      @(posedge clk_sys);
      if (!bb)
         req <= 1'b0;
   endtask
   task automatic res(input logic t, input logic i, input logic bz);
      @(negedge clk_sys);
      chk("cmd_taken", t, cmd_taken);
      chk("illegal_cmd", i, illegal_cmd);
      chk("device_busy", bz, device_busy);
      @(posedge clk_sys);
   endtask
   task automatic wait_st(input int b, input logic [7:0] e, input int mx);
      int i;
      for (i = 0; i < mx; i++)
      begin
         @(negedge clk_sys);
         if (bank_state_flat[8*b +: 8] === e)
            break;
      end
      chk($sformatf("bank %0d state", b), e, bank_state_flat[8*b +: 8]);
      @(posedge clk_sys);
   endtask
   task automatic wait_idle();
      for (k = 0; k < 8 && all_banks_idle !== 1'b1; k++)
         @(negedge clk_sys);
      chk("all_banks_idle", 8'h1, all_banks_idle);
      @(posedge clk_sys);
   endtask
   task automatic final_report();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (2000) @(posedge clk_sys);
      n_errors++;
      final_report();
   end
   initial
   begin
      rst = 1'b1;
      cke = 1'b1;
      srx = 1'b0;
      req = 1'b0;
      a10 = 1'b0;
      cmd = SBS_CMD_NOP;
      bank = 2'h0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      for (k = 0; k < 4; k++)
         wait_st(k, SBS_ST_IDLE, 1);
      repeat (8) @(posedge clk_sys);
      send(SBS_CMD_PRE, 2'h0, 1'b0, 1'b0);
      res(1'b1, 1'b0, 1'b0);
      wait_st(0, SBS_ST_IDLE, 1);
      send(SBS_CMD_ACT, 2'h0, 1'b0, 1'b1);
      send(SBS_CMD_ACT, 2'h0, 1'b0, 1'b0);
      res(1'b0, 1'b1, 1'b0);
      wait_st(0, SBS_ST_ROWACT, 4);
      send(SBS_CMD_ACT, 2'h1, 1'b0, 1'b0);
      wait_st(1, SBS_ST_ROWACT, 4);
      send(SBS_CMD_READ, 2'h0, 1'b1, 1'b0);
      wait_st(0, SBS_ST_RDAP, 2);
      wait_st(0, SBS_ST_IDLE, 10);
      send(SBS_CMD_READ, 2'h1, 1'b0, 1'b0);
      wait_st(1, SBS_ST_READ, 2);
      wait_st(1, SBS_ST_ROWACT, 8);
      send(SBS_CMD_ACT, 2'h0, 1'b0, 1'b0);
      wait_st(0, SBS_ST_ROWACT, 4);
      send(SBS_CMD_READ, 2'h0, 1'b1, 1'b1);
      send(SBS_CMD_READ, 2'h1, 1'b0, 1'b0);
      wait_st(0, SBS_ST_IDLE, 4);
      wait_st(1, SBS_ST_ROWACT, 8);
      send(SBS_CMD_ACT, 2'h0, 1'b0, 1'b0);
      wait_st(0, SBS_ST_ROWACT, 4);
      send(SBS_CMD_WRITE, 2'h0, 1'b1, 1'b1);
      send(SBS_CMD_WRITE, 2'h1, 1'b0, 1'b0);
      repeat (3) @(negedge clk_sys);
      chk("bank 0 recovery", SBS_ST_WRAP, bank_state_flat[7:0]);
      wait_st(0, SBS_ST_IDLE, 7);
      wait_st(1, SBS_ST_ROWACT, 8);
      send(SBS_CMD_ACT, 2'h2, 1'b0, 1'b0);
      wait_st(2, SBS_ST_ROWACT, 4);
      send(SBS_CMD_READ, 2'h1, 1'b0, 1'b1);
      send(SBS_CMD_READ, 2'h2, 1'b0, 1'b0);
      repeat (2) @(negedge clk_sys);
      chk("bank 1 cut late", SBS_ST_READ, bank_state_flat[15:8]);
      @(negedge clk_sys);
      chk("bank 1 cut", SBS_ST_ROWACT, bank_state_flat[15:8]);
      @(posedge clk_sys);
      send(SBS_CMD_READ, 2'h1, 1'b0, 1'b1);
      send(SBS_CMD_BST, 2'h3, 1'b0, 1'b0);
      wait_st(1, SBS_ST_ROWACT, 2);
      send(SBS_CMD_REF, 2'h0, 1'b0, 1'b0);
      res(1'b0, 1'b1, 1'b0);
      send(SBS_CMD_PRE, 2'h2, 1'b1, 1'b0);
      res(1'b1, 1'b0, 1'b1);
      wait_idle();
      send(SBS_CMD_REF, 2'h0, 1'b0, 1'b0);
      res(1'b1, 1'b0, 1'b1);
      send(SBS_CMD_ACT, 2'h2, 1'b0, 1'b0);
      res(1'b0, 1'b1, 1'b1);
      wait_idle();
      send(SBS_CMD_MRS, 2'h0, 1'b0, 1'b0);
      res(1'b1, 1'b0, 1'b1);
      wait_idle();
      send(SBS_CMD_ACT, 2'h0, 1'b0, 1'b1);
      send(SBS_CMD_PRE, 2'h0, 1'b1, 1'b0);
      res(1'b0, 1'b1, 1'b0);
      wait_st(0, SBS_ST_ROWACT, 4);
      cke <= 1'b0;
      repeat (4) @(posedge clk_sys);
      send(SBS_CMD_PRE, 2'h0, 1'b0, 1'b0);
      res(1'b0, 1'b0, 1'b0);
      cke <= 1'b1;
      repeat (6) @(posedge clk_sys);
      srx <= 1'b1;
      @(posedge clk_sys);
      srx <= 1'b0;
      send(SBS_CMD_PRE, 2'h0, 1'b0, 1'b0);
      res(1'b0, 1'b0, 1'b0);
      repeat (2) @(posedge clk_sys);
      send(SBS_CMD_PRE, 2'h0, 1'b0, 1'b0);
      res(1'b1, 1'b0, 1'b0);
      wait_st(0, SBS_ST_IDLE, 4);
      final_report();
   end
endmodule
`default_nettype wire
